/* logic/swm_pkg.sv */
package swm_pkg;

    // base clock, cycles per microsecond
    localparam int CLK_MHZ = 25;

    // line timing in microseconds
    localparam int RST_LOW_US     = 480;
    localparam int RST_HIGH_US    = 480;
    localparam int PRES_SAMPLE_US = 70;
    localparam int SLOT_US        = 70;
    localparam int W1_LOW_US      = 6;
    localparam int W0_LOW_US      = 65;
    localparam int RD_LOW_US      = 2;
    localparam int RD_SAMPLE_US   = 13;
    localparam int REC_US         = 2;
    localparam int DP_US          = 5;
    localparam int PP_US          = 480;
    localparam int DV_US          = 5;

    // documented limits, checked by the assertions
    localparam int W1_MIN_US   = 1;
    localparam int W1_MAX_US   = 15;
    localparam int SLOT_MIN_US = 60;
    localparam int SLOT_MAX_US = 120;
    localparam int RDV_MAX_US  = 15;
    localparam int REC_MIN_US  = 1;
    localparam int DP_MIN_US   = 5;
    localparam int DV_MIN_US   = 5;

    // command opcodes
    localparam logic [1:0] OP_RESET   = 2'h0;
    localparam logic [1:0] OP_BYTE    = 2'h1;
    localparam logic [1:0] OP_PROG    = 2'h2;
    localparam logic [1:0] OP_LOADCRC = 2'h3;

    // crc handling of a byte command
    localparam logic [1:0] CRC_NONE  = 2'h0;
    localparam logic [1:0] CRC_SHIFT = 2'h1;
    localparam logic [1:0] CRC_CLEAR = 2'h2;

    localparam logic [15:0] CRC_POLY_REV = 16'ha001;
    localparam logic [15:0] CRC_RESET    = 16'h0000;
    localparam logic [7:0]  HI_ADDR_KEEP = 8'h07;
    localparam logic [7:0]  HI_ADDR_SET  = 8'hf8;
    localparam logic [2:0]  HI_ADDR_BIT  = 3'h3;
    localparam logic [2:0]  BIT_LAST     = 3'h7;
    localparam logic [7:0]  READ_FILL    = 8'hff;
    localparam logic [15:0] RUN_MAX      = 16'hffff;

    typedef enum logic [2:0] {
        K_RST = 3'h0,
        K_W1  = 3'h1,
        K_W0  = 3'h2,
        K_RD  = 3'h3,
        K_PRG = 3'h4
    } swm_kind_t;

    typedef enum logic [8:0] {
        ST_IDLE    = 9'h001,
        ST_RSTLOW  = 9'h002,
        ST_RSTHIGH = 9'h004,
        ST_SLOTLOW = 9'h008,
        ST_SLOTEND = 9'h010,
        ST_RECOV   = 9'h020,
        ST_PRGWAIT = 9'h040,
        ST_PRGON   = 9'h080,
        ST_PRGDONE = 9'h100
    } swm_state_t;

endpackage : swm_pkg

/* logic/swm_crc_if.sv */
`timescale 1ns/1ps
`default_nettype none

interface swm_crc_if;
    logic        clear;
    logic        load;
    logic        shift;
    logic        bitIn;
    logic [15:0] loadVal;
    logic [15:0] crc;

    modport gen  (input clear, load, shift, bitIn, loadVal, output crc);
    modport user (output clear, load, shift, bitIn, loadVal, input crc);
endinterface : swm_crc_if

`default_nettype wire

/* logic/swm_crc16.sv */
`timescale 1ns/1ps
`default_nettype none

module swm_crc16
    import swm_pkg::*;
(
    // clock and reset
    input  wire logic mclk,
    input  wire logic resetn,
    // generator controls
    swm_crc_if.gen    crcPort
);

    logic [15:0] crc;
    logic [15:0] next_crc;

    // lsb-first serial step of x^16 + x^15 + x^2 + 1
    function automatic logic [15:0] crcStep(input logic [15:0] c, input logic b);
        logic [15:0] s;
        s = c >> 1;
        return (c[0] ^ b) ? (s ^ CRC_POLY_REV) : s;
    endfunction : crcStep

    always_comb begin
        next_crc = crc;
        if (crcPort.clear) begin
            next_crc = CRC_RESET;
        end else if (crcPort.load) begin
            next_crc = crcPort.loadVal;
        end else if (crcPort.shift) begin
            next_crc = crcStep(crc, crcPort.bitIn);
        end
    end

    always_ff @(posedge mclk) begin
        if (!resetn) begin
            crc <= CRC_RESET;
        end else begin
            crc <= next_crc;
        end
    end

    assign crcPort.crc = crc;

endmodule : swm_crc16

`default_nettype wire

/* logic/swm_host.sv */
`timescale 1ns/1ps
`default_nettype none

// Summary of operation
// - device sends crc before programming; host reads it first
// - host never compares crcs; the user decides to continue or abort
// - host may set top five high-address bits when pull-up supply is low
// - host keeps line high at least 480 us after reset
// - host samples read slot late but before 15 us
// - every slot lasts 60 to 120 us from falling edge
// - write one: line low 1 to 15 us
// - write zero: line low 60 to 120 us
// - at least 1 us released recovery between slots
// - every transaction opens with reset low at least 480 us
// - host waits at least 5 us after crc before program voltage
// - program voltage held at least 480 us per byte
// - host waits at least 5 us after program pulse before verify slots
module swm_host
    import swm_pkg::*;
#(
    parameter int RST_LOW_TIME  = RST_LOW_US,
    parameter int RST_HIGH_TIME = RST_HIGH_US,
    parameter int PP_TIME       = PP_US
) (
    // clock and reset
    input  wire logic        mclk,
    input  wire logic        resetn,
    // command
    input  wire logic        cmdValid,
    output logic             cmdReady,
    input  wire logic [1:0]  cmdOp,
    input  wire logic [7:0]  cmdData,
    input  wire logic        cmdRead,
    input  wire logic        cmdHighAddr,
    input  wire logic [1:0]  cmdCrcMode,
    input  wire logic [15:0] cmdAddr,
    input  wire logic        lowSupply,
    // response
    output logic             respValid,
    output logic [7:0]       respData,
    output logic             presence,
    output logic [15:0]      crcValue,
    // line
    input  wire logic        lineIn,
    output logic             lineOut,
    output logic             lineOe,
    output logic             progEn
);

    localparam logic [4:0] PRE_LAST = 5'(CLK_MHZ - 1);

    swm_crc_if crcIf ();

    swm_crc16 crcGen (
        .mclk    (mclk),
        .resetn  (resetn),
        .crcPort (crcIf)
    );

    swm_state_t  st,       next_st;
    swm_kind_t   kind,     next_kind;
    logic [4:0]  pre,      next_pre;
    logic [9:0]  usCnt,    next_usCnt;
    logic [2:0]  bitIdx,   next_bitIdx;
    logic [7:0]  shiftReg, next_shiftReg;
    logic        rxBit,    next_rxBit;
    logic        doRead,   next_doRead;
    logic        hiAddr,   next_hiAddr;
    logic        crcOn,    next_crcOn;
    logic        resp,     next_resp;
    logic [7:0]  rdata,    next_rdata;
    logic        pres,     next_pres;
    logic        usTick;
    logic        sampleNow;
    logic        bitVal;
    int          lowLim;

    function automatic logic timeUp(input logic tick, input logic [9:0] cnt, input int lim);
        return tick && (int'(cnt) == lim - 1);
    endfunction : timeUp

    function automatic swm_kind_t slotKind(input logic rd, input logic b);
        return rd ? K_RD : (b ? K_W1 : K_W0);
    endfunction : slotKind

    assign usTick = (pre == PRE_LAST);
    assign lowLim = (kind == K_W0) ? W0_LOW_US : ((kind == K_W1) ? W1_LOW_US : RD_LOW_US);

    always_comb begin
        next_st       = st;
        next_kind     = kind;
        next_pre      = usTick ? 5'h00 : pre + 5'h01;
        next_usCnt    = usTick ? usCnt + 10'h001 : usCnt;
        next_bitIdx   = bitIdx;
        next_shiftReg = shiftReg;
        next_rxBit    = rxBit;
        next_doRead   = doRead;
        next_hiAddr   = hiAddr;
        next_crcOn    = crcOn;
        next_resp     = 1'b0;
        next_rdata    = rdata;
        next_pres     = pres;
        crcIf.clear   = 1'b0;
        crcIf.load    = 1'b0;
        crcIf.shift   = 1'b0;
        crcIf.bitIn   = 1'b0;
        crcIf.loadVal = CRC_RESET;
        sampleNow     = 1'b0;
        bitVal        = doRead ? rxBit : shiftReg[0];
        case (st)
            ST_IDLE: begin
                next_pre   = 5'h00;
                next_usCnt = 10'h000;
                if (cmdValid) begin
                    case (cmdOp)
                        OP_RESET: begin
                            next_st   = ST_RSTLOW;
                            next_kind = K_RST;
                        end
                        OP_BYTE: begin
                            next_doRead = cmdRead;
                            next_hiAddr = cmdHighAddr && !cmdRead;
                            next_crcOn  = (cmdCrcMode != CRC_NONE);
                            next_bitIdx = 3'h0;
                            if (cmdRead) begin
                                next_shiftReg = READ_FILL;
                            end else if (cmdHighAddr && lowSupply) begin
                                next_shiftReg = cmdData | HI_ADDR_SET;
                            end else begin
                                next_shiftReg = cmdData;
                            end
                            next_kind   = slotKind(cmdRead, next_shiftReg[0]);
                            crcIf.clear = (cmdCrcMode == CRC_CLEAR);
                            next_st     = ST_SLOTLOW;
                        end
                        OP_PROG: begin
                            next_st = ST_PRGWAIT;
                        end
                        default: begin
                            // mirror of the device: address as given, top bits forced low
                            crcIf.load    = 1'b1;
                            crcIf.loadVal = {cmdAddr[15:8] & HI_ADDR_KEEP, cmdAddr[7:0]};
                            next_resp     = 1'b1;
                        end
                    endcase
                end
            end
            ST_RSTLOW: begin
                if (timeUp(usTick, usCnt, RST_LOW_TIME)) begin
                    next_st    = ST_RSTHIGH;
                    next_usCnt = 10'h000;
                end
            end
            ST_RSTHIGH: begin
                if (timeUp(usTick, usCnt, PRES_SAMPLE_US)) begin
                    next_pres = !lineIn;
                end
                if (timeUp(usTick, usCnt, RST_HIGH_TIME)) begin
                    next_st   = ST_IDLE;
                    next_resp = 1'b1;
                end
            end
            ST_SLOTLOW: begin
                if (timeUp(usTick, usCnt, lowLim)) begin
                    next_st    = ST_SLOTEND;
                    next_usCnt = 10'h000;
                end
            end
            ST_SLOTEND: begin
                if (kind == K_RD && timeUp(usTick, usCnt, RD_SAMPLE_US - RD_LOW_US)) begin
                    sampleNow  = 1'b1;
                    next_rxBit = lineIn;
                end
                if (timeUp(usTick, usCnt, SLOT_US - lowLim)) begin
                    next_shiftReg = {bitVal, shiftReg[7:1]};
                    crcIf.shift   = crcOn;
                    // the device hashes the high address with its top bits cleared
                    crcIf.bitIn   = (hiAddr && bitIdx >= HI_ADDR_BIT) ? 1'b0 : bitVal;
                    next_st       = ST_RECOV;
                    next_usCnt    = 10'h000;
                end
            end
            ST_RECOV: begin
                if (timeUp(usTick, usCnt, REC_US)) begin
                    next_usCnt = 10'h000;
                    if (bitIdx == BIT_LAST) begin
                        next_st    = ST_IDLE;
                        next_resp  = 1'b1;
                        next_rdata = shiftReg;
                    end else begin
                        next_bitIdx = bitIdx + 3'h1;
                        next_kind   = slotKind(doRead, shiftReg[0]);
                        next_st     = ST_SLOTLOW;
                    end
                end
            end
            ST_PRGWAIT: begin
                if (timeUp(usTick, usCnt, DP_US)) begin
                    next_st    = ST_PRGON;
                    next_kind  = K_PRG;
                    next_usCnt = 10'h000;
                end
            end
            ST_PRGON: begin
                if (timeUp(usTick, usCnt, PP_TIME)) begin
                    next_st    = ST_PRGDONE;
                    next_usCnt = 10'h000;
                end
            end
            ST_PRGDONE: begin
                if (timeUp(usTick, usCnt, DV_US)) begin
                    next_st   = ST_IDLE;
                    next_resp = 1'b1;
                end
            end
            default: begin
                next_st = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge mclk) begin
        if (!resetn) begin
            st       <= ST_IDLE;
            kind     <= K_RST;
            pre      <= 5'h00;
            usCnt    <= 10'h000;
            bitIdx   <= 3'h0;
            shiftReg <= 8'h00;
            rxBit    <= 1'b0;
            doRead   <= 1'b0;
            hiAddr   <= 1'b0;
            crcOn    <= 1'b0;
            resp     <= 1'b0;
            rdata    <= 8'h00;
            pres     <= 1'b0;
        end else begin
            st       <= next_st;
            kind     <= next_kind;
            pre      <= next_pre;
            usCnt    <= next_usCnt;
            bitIdx   <= next_bitIdx;
            shiftReg <= next_shiftReg;
            rxBit    <= next_rxBit;
            doRead   <= next_doRead;
            hiAddr   <= next_hiAddr;
            crcOn    <= next_crcOn;
            resp     <= next_resp;
            rdata    <= next_rdata;
            pres     <= next_pres;
        end
    end

    // comparing against the complemented device crc is left to the user
    assign cmdReady  = (st == ST_IDLE);
    assign respValid = resp;
    assign respData  = rdata;
    assign presence  = pres;
    assign crcValue  = crcIf.crc;
    assign lineOut   = 1'b0;
    assign lineOe    = (st == ST_RSTLOW) || (st == ST_SLOTLOW);
    assign progEn    = (st == ST_PRGON);

    // run-length counters watched by the assertions
    logic [15:0] lowRun,  next_lowRun;
    logic [15:0] highRun, next_highRun;
    logic [15:0] progRun, next_progRun;
    logic [15:0] slotRun, next_slotRun;

    function automatic logic [15:0] sat(input logic [15:0] x);
        return (x == RUN_MAX) ? x : x + 16'h0001;
    endfunction : sat

    always_comb begin
        next_lowRun  = lineOe ? sat(lowRun) : 16'h0000;
        next_highRun = (lineOe || progEn) ? 16'h0000 : sat(highRun);
        next_progRun = progEn ? sat(progRun) : 16'h0000;
        next_slotRun = (lineOe && lowRun == 16'h0000) ? 16'h0001 : sat(slotRun);
    end

    always_ff @(posedge mclk) begin
        if (!resetn) begin
            lowRun  <= 16'h0000;
            highRun <= RUN_MAX;
            progRun <= 16'h0000;
            slotRun <= 16'h0000;
        end else begin
            lowRun  <= next_lowRun;
            highRun <= next_highRun;
            progRun <= next_progRun;
            slotRun <= next_slotRun;
        end
    end

    a_reset_low_min: assert property (@(posedge mclk) disable iff (!resetn)
        $fell(lineOe) && kind == K_RST |-> int'(lowRun) >= RST_LOW_TIME * CLK_MHZ)
        else $error("reset pulse too short");

    a_post_reset_high: assert property (@(posedge mclk) disable iff (!resetn)
        $rose(lineOe) && $past(kind) == K_RST |-> int'(highRun) >= RST_HIGH_TIME * CLK_MHZ)
        else $error("line not high long enough after reset");

    a_write_one_low: assert property (@(posedge mclk) disable iff (!resetn)
        $fell(lineOe) && kind == K_W1 |->
        int'(lowRun) >= W1_MIN_US * CLK_MHZ && int'(lowRun) <= W1_MAX_US * CLK_MHZ)
        else $error("write one low time out of range");

    a_write_zero_low: assert property (@(posedge mclk) disable iff (!resetn)
        $fell(lineOe) && kind == K_W0 |->
        int'(lowRun) >= SLOT_MIN_US * CLK_MHZ && int'(lowRun) <= SLOT_MAX_US * CLK_MHZ)
        else $error("write zero low time out of range");

    a_read_sample_time: assert property (@(posedge mclk) disable iff (!resetn)
        sampleNow |-> !lineOe && int'(slotRun) <= RDV_MAX_US * CLK_MHZ)
        else $error("read sample too late");

    a_slot_length: assert property (@(posedge mclk) disable iff (!resetn)
        st == ST_RECOV && $past(st) == ST_SLOTEND |->
        int'(slotRun) >= SLOT_MIN_US * CLK_MHZ && int'(slotRun) <= SLOT_MAX_US * CLK_MHZ)
        else $error("slot length out of range");

    a_slot_recovery: assert property (@(posedge mclk) disable iff (!resetn)
        $rose(lineOe) |-> int'(highRun) >= REC_MIN_US * CLK_MHZ)
        else $error("recovery time too short");

    a_program_delay: assert property (@(posedge mclk) disable iff (!resetn)
        $rose(progEn) |-> !lineOe && int'(highRun) >= DP_MIN_US * CLK_MHZ)
        else $error("program pulse started too early");

    a_program_width: assert property (@(posedge mclk) disable iff (!resetn)
        $fell(progEn) |-> int'(progRun) >= PP_TIME * CLK_MHZ ##1 !progEn)
        else $error("program pulse too short");

    a_verify_delay: assert property (@(posedge mclk) disable iff (!resetn)
        $rose(lineOe) && $past(kind) == K_PRG |-> int'(highRun) >= DV_MIN_US * CLK_MHZ)
        else $error("verify slot started too soon after program pulse");

endmodule : swm_host

`default_nettype wire

/* tb/swm_dev_model.sv */
`timescale 1ns/1ps
`default_nettype none

module swm_dev_model
    import swm_pkg::*;
#(
    parameter int RST_MIN = 150 * CLK_MHZ
) (
    // clock
    input  wire logic        mclk,
    // line
    input  wire logic        line,
    output logic             devOe,
    // observation
    output logic [31:0]      rxWord,
    output logic [15:0]      devCrc
);
    localparam int PD_START = 25 * CLK_MHZ;
    localparam int PD_END   = 100 * CLK_MHZ;
    localparam int SAMPLE   = 30 * CLK_MHZ;

    int          lowRun   = 0;
    int          slotCnt  = 0;
    int          presCnt  = 0;
    int          nBits    = 48;
    logic        prevLine = 1'b1;
    logic        bitNow;
    logic [15:0] txWord   = 16'h0000;

    initial begin
        devOe = 1'b0;
        rxWord = '0;
        devCrc = '0;
    end

    // behavioural: blocking updates keep the slot bookkeeping in one place
    always @(posedge mclk) begin
        if (!prevLine && line && lowRun >= RST_MIN) begin
            presCnt = 1;
            nBits = 0;
            devCrc = CRC_RESET;
        end
        lowRun = line ? 0 : lowRun + 1;
        if (presCnt != 0) begin
            presCnt = (presCnt == PD_END) ? 0 : presCnt + 1;
        end else if (prevLine && !line) begin
            slotCnt = 1;
        end else if (slotCnt != 0) begin
            slotCnt = slotCnt + 1;
        end
        if (slotCnt == SAMPLE) begin
            if (nBits < 32) begin
                bitNow = (nBits >= 19 && nBits < 24) ? 1'b0 : line;
                rxWord[nBits] = line;
                devCrc = (devCrc >> 1) ^ ((devCrc[0] ^ bitNow) ? CRC_POLY_REV : 16'h0000);
                if (nBits == 31) begin
                    txWord = ~devCrc;
                end
            end
            // never stops on a mismatch, the master decides
            if (nBits < 48) begin
                nBits = nBits + 1;
            end
            slotCnt = 0;
        end
        // zero held from fall to 30 us, 15 us past the valid window
        devOe <= (presCnt >= PD_START) ||
                 (nBits >= 32 && nBits < 48 && slotCnt != 0 && !txWord[nBits-32]);
        prevLine = line;
    end
endmodule : swm_dev_model

`default_nettype wire

/* tb/single_wire_slave_write_crc_bench.sv */
`timescale 1ns/1ps
`default_nettype none

module single_wire_slave_write_crc_bench
    import swm_pkg::*;
;
    // shortened so the run stays short; presence ends before 120 us
    localparam int RST_LOW  = 110;
    localparam int RST_HIGH = 120;
    localparam int PP       = 10;

    logic        mclk, resetn, cmdValid, cmdReady, cmdRead, cmdHighAddr, lowSupply;
    logic        respValid, presence, lineIn, lineOut, lineOe, progEn, devOe;
    logic [1:0]  cmdOp, cmdCrcMode;
    logic [7:0]  cmdData, respData, b, w;
    logic [15:0] cmdAddr, crcValue, devCrc, expCrc, a;
    logic [31:0] rxWord, seed, sent, wireWord;
    int          badCount, checksDone, progCnt, n;

    // open-drain line with pull-up
    assign lineIn = (lineOe ? lineOut : 1'b1) & !devOe;

    swm_host #(.RST_LOW_TIME(RST_LOW), .RST_HIGH_TIME(RST_HIGH), .PP_TIME(PP)) DUT (
        .mclk(mclk), .resetn(resetn), .cmdValid(cmdValid), .cmdReady(cmdReady),
        .cmdOp(cmdOp), .cmdData(cmdData), .cmdRead(cmdRead), .cmdHighAddr(cmdHighAddr),
        .cmdCrcMode(cmdCrcMode), .cmdAddr(cmdAddr), .lowSupply(lowSupply),
        .respValid(respValid), .respData(respData), .presence(presence),
        .crcValue(crcValue), .lineIn(lineIn), .lineOut(lineOut), .lineOe(lineOe),
        .progEn(progEn));

    // reset threshold sits between the longest write zero and the shortened reset
    swm_dev_model #(.RST_MIN(100 * CLK_MHZ)) model (
        .mclk(mclk), .line(lineIn), .devOe(devOe), .rxWord(rxWord), .devCrc(devCrc));

    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : rnd

    function automatic logic [15:0] crcb(input logic [15:0] c, input logic [7:0] d);
        logic [15:0] r;
        r = c;
        for (int i = 0; i < 8; i++) begin
            r = (r >> 1) ^ ((r[0] ^ d[i]) ? 16'ha001 : 16'h0000);
        end
        return r;
    endfunction : crcb

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checksDone++;
        if (seen !== exp) begin
            badCount++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic summarize();
        if (badCount == 0 && checksDone > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : summarize

    // entered at a falling edge; counts cycles from the taking edge
    task automatic run(input logic [1:0] op, input logic [7:0] d, input logic [3:0] ctl,
                       input logic [15:0] ad, output int cnt);
        check("ready", cmdReady, 1'b1);
        cmdOp = op;
        cmdData = d;
        {cmdRead, cmdHighAddr, cmdCrcMode} = ctl;
        cmdAddr = ad;
        cmdValid = 1'b1;
        @(negedge mclk);
        cmdValid = 1'b0;
        cnt = 0;
        while (respValid !== 1'b1) begin
            if (cnt > 20000) begin
                badCount++;
                summarize();
            end
            @(negedge mclk);
            cnt++;
        end
    endtask : run

    initial begin
        mclk = 1'b0;
        forever #20 mclk = ~mclk;
    end

    always @(posedge mclk) begin
        if (progEn === 1'b1) begin
            progCnt++;
        end
    end

    initial begin
        seed = 32'd50;
        badCount = 0;
        checksDone = 0;
        progCnt = 0;
        resetn = 1'b0;
        cmdValid = 1'b0;
        cmdOp = OP_RESET;
        cmdData = 8'h00;
        cmdRead = 1'b0;
        cmdHighAddr = 1'b0;
        cmdCrcMode = CRC_NONE;
        cmdAddr = 16'h0000;
        lowSupply = 1'b0;
        repeat (4) @(negedge mclk);
        resetn = 1'b1;
        run(OP_RESET, 8'h00, 4'h0, 16'h0000, n);
        check("reset time", n, (RST_LOW + RST_HIGH) * CLK_MHZ);
        check("presence", presence, 1'b1);
        // command, address low, address high, data
        sent = rnd();
        // corner: low supply forcing on the high address byte
        lowSupply = 1'b1;
        expCrc = CRC_RESET;
        for (int i = 0; i < 4; i++) begin
            b = sent[8*i +: 8];
            w = (i == 2 && lowSupply) ? (b | 8'hf8) : b;
            wireWord[8*i +: 8] = w;
            run(OP_BYTE, b, {1'b0, i == 2, i == 0 ? CRC_CLEAR : CRC_SHIFT}, 16'h0000, n);
            check("write time", n, 8 * (SLOT_US + REC_US) * CLK_MHZ);
            check("sent byte", respData, w);
            expCrc = crcb(expCrc, (i == 2) ? (b & 8'h07) : b);
        end
        check("device rx", rxWord, wireWord);
        check("host crc", crcValue, expCrc);
        check("device crc", devCrc, expCrc);
        for (int i = 0; i < 2; i++) begin
            run(OP_BYTE, 8'h00, {2'b10, CRC_NONE}, 16'h0000, n);
            b = ~expCrc[8*i +: 8];
            check("crc byte", respData, b);
        end
        // no crc comparison gate: program proceeds anyway
        run(OP_PROG, 8'h00, 4'h0, 16'h0000, n);
        check("prog time", n, (DP_US + PP + DV_US) * CLK_MHZ);
        check("prog width", progCnt, PP * CLK_MHZ);
        sent = rnd();
        a = sent[15:0] | 16'hf800;
        run(OP_LOADCRC, 8'h00, 4'h0, a, n);
        check("load time", n, 0);
        check("loaded crc", crcValue, {a[15:8] & 8'h07, a[7:0]});
        // a reset after programming and the crc load also exercises the verify delay
        run(OP_RESET, 8'h00, 4'h0, 16'h0000, n);
        check("second reset time", n, (RST_LOW + RST_HIGH) * CLK_MHZ);
        check("second presence", presence, 1'b1);
        summarize();
    end
endmodule : single_wire_slave_write_crc_bench

`default_nettype wire
